/* File: rtl/csow_clock_source.sv */
// CPU clock source selection with oscillator watchdog failover
`include "csow_defs.svh"

module csow_clock_source #(
  parameter int unsigned WD_OVF_TICKS = `CSOW_WD_OVF_TICKS,
  parameter int unsigned FR_HALF_CYC  = `CSOW_FREE_RUN_HALF_CYC,
  parameter int unsigned STRAP_SETTLE = `CSOW_STRAP_SETTLE_CYC
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_crystal_input,
  input  wire logic [2:0]                  i_clock_mode_straps,
  input  wire logic [`CSOW_SYS_CFG_W-1:0]  i_system_config_reg,
  input  wire logic                        i_clock_fail_irq_clr,
  output logic                             o_cpu_clk,
  output csow_pkg::csow_src_t              o_cpu_clk_src,
  output logic                             o_clock_fail_irq,
  output logic                             o_pll_power_on,
  output logic                             o_mode_ready
);
  localparam logic [7:0] FR_LAST     = 8'(FR_HALF_CYC - 1);
  localparam logic [1:0] SETTLE_LAST = 2'(STRAP_SETTLE - 1);
  localparam csow_pkg::csow_top_t TOP_RST = '{
    state:     csow_pkg::CSOW_ST_STRAP,
    src:       csow_pkg::CSOW_SRC_DIRECT,
    wd_enable: 1'b1,
    half_per:  16'h0001,
    default:   '0
  };

  if (FR_HALF_CYC < 1 || FR_HALF_CYC > 256) begin : g_bad_fr
    $error("csow_clock_source: FR_HALF_CYC must be 1 to 256");
  end
  if (STRAP_SETTLE < 3 || STRAP_SETTLE > 4) begin : g_bad_settle
    $error("csow_clock_source: STRAP_SETTLE must be 3 or 4");
  end

  csow_pkg::csow_top_t r;
  csow_pkg::csow_top_t next_r;
  logic                xtal_level;
  logic                xtal_rise;
  logic                xtal_edge;
  logic [2:0]          strap_level;
  logic                fr_rise;
  logic                wd_active;
  logic [15:0]         target;

  csow_wd_if wd_if ();

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  csow_pin_sync #(.WIDTH(1)) u_xtal_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_crystal_input),
    .o_level   (xtal_level),
    .o_rise    (xtal_rise),
    .o_edge    (xtal_edge)
  );

  csow_pin_sync #(.WIDTH(3)) u_strap_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_clock_mode_straps),
    .o_level   (strap_level),
    .o_rise    (),
    .o_edge    ()
  );

  // ==========================================================
  // Watchdog counter
  // ==========================================================
  csow_wd_counter #(.OVF_TICKS(WD_OVF_TICKS)) u_wd_counter (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .wd        (wd_if.cnt)
  );

  assign wd_if.enable = wd_active;
  assign wd_if.tick   = fr_rise;
  assign wd_if.clear  = xtal_edge;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [3:0] pll_factor(input logic [2:0] code);
    logic [31:0] table_v;
    table_v = `CSOW_PLL_FACTOR_TABLE;
    return table_v[{code, 2'b00} +: 4];
  endfunction

  // Move half period toward the target by a quarter of the gap plus one
  function automatic logic [15:0] pll_step(input logic [15:0] cur,
                                           input logic [15:0] tgt);
    logic [15:0] gap;
    gap = 16'h0000;
    if (tgt > cur) begin
      gap = tgt - cur;
      return cur + 16'h0001 + (gap >> 2);
    end else if (tgt < cur) begin
      gap = cur - tgt;
      return cur - 16'h0001 - (gap >> 2);
    end
    return cur;
  endfunction

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    next_r    = r;
    fr_rise   = 1'b0;
    target    = 16'h0001;
    wd_active = (r.state == csow_pkg::CSOW_ST_RUN) && r.wd_enable &&
                (r.src == csow_pkg::CSOW_SRC_DIRECT ||
                 r.src == csow_pkg::CSOW_SRC_PRESCALE);

    // Free-running PLL clock as a divided level
    if (r.pll_power) begin
      if (r.fr_div == FR_LAST) begin
        next_r.fr_div   = 8'h00;
        next_r.fr_level = ~r.fr_level;
        fr_rise         = ~r.fr_level;
      end else begin
        next_r.fr_div = r.fr_div + 8'h01;
      end
    end else begin
      next_r.fr_div   = 8'h00;
      next_r.fr_level = 1'b0;
    end

    case (r.state)
      csow_pkg::CSOW_ST_STRAP: begin
        next_r.settle = r.settle + 2'h1;
        if (r.settle == SETTLE_LAST) begin
          next_r.strap  = strap_level;
          next_r.factor = pll_factor(strap_level);
          next_r.state  = csow_pkg::CSOW_ST_RUN;
          next_r.ready  = 1'b1;
          if (strap_level == `CSOW_STRAP_PRESCALE) begin
            next_r.src = csow_pkg::CSOW_SRC_PRESCALE;
          end else if (strap_level == `CSOW_STRAP_DIRECT) begin
            next_r.src = csow_pkg::CSOW_SRC_DIRECT;
          end else begin
            next_r.src = csow_pkg::CSOW_SRC_PLL;
          end
        end
      end
      csow_pkg::CSOW_ST_RUN: begin
        next_r.wd_enable = ~i_system_config_reg[`CSOW_OSC_WATCH_DISABLE_BIT];
        next_r.pll_power = (r.src == csow_pkg::CSOW_SRC_PLL) || wd_active;
        if (wd_if.overflow && wd_active) begin
          next_r.state     = csow_pkg::CSOW_ST_FAILED;
          next_r.src       = csow_pkg::CSOW_SRC_FREE_RUN;
          next_r.pll_power = 1'b1;
        end
      end
      csow_pkg::CSOW_ST_FAILED: begin
        next_r.pll_power = 1'b1;
      end
      default: begin
        next_r.state = csow_pkg::CSOW_ST_STRAP;
      end
    endcase

    // CPU clock generation per source
    case (r.src)
      csow_pkg::CSOW_SRC_DIRECT: begin
        next_r.cpu_clk = xtal_level;
      end
      csow_pkg::CSOW_SRC_PRESCALE: begin
        if (xtal_rise) begin
          next_r.cpu_clk = ~r.cpu_clk;
        end
      end
      csow_pkg::CSOW_SRC_PLL: begin
        if (r.per_cnt != 16'hFFFF) begin
          next_r.per_cnt = r.per_cnt + 16'h0001;
        end
        if (xtal_rise) begin
          next_r.per_cnt = 16'h0001;
          if (r.edge_cnt >= r.factor - 4'h1) begin
            next_r.edge_cnt = 4'h0;
            target = 16'(r.per_cnt / 16'({r.factor, 1'b0}));
            if (target == 16'h0000) begin
              target = 16'h0001;
            end
            next_r.half_per = pll_step(r.half_per, target);
          end else begin
            next_r.edge_cnt = r.edge_cnt + 4'h1;
          end
        end
        if (r.ph_cnt + 16'h0001 >= r.half_per) begin
          next_r.ph_cnt  = 16'h0000;
          next_r.cpu_clk = ~r.cpu_clk;
        end else begin
          next_r.ph_cnt = r.ph_cnt + 16'h0001;
        end
      end
      csow_pkg::CSOW_SRC_FREE_RUN: begin
        next_r.cpu_clk = r.fr_level;
      end
      default: begin
        next_r.cpu_clk = 1'b0;
      end
    endcase

    // Interrupt flag: clear first so a same-cycle overflow wins
    if (i_clock_fail_irq_clr) begin
      next_r.fail_irq = 1'b0;
    end
    if (wd_if.overflow && wd_active) begin
      next_r.fail_irq = 1'b1;
    end
  end

  // ==========================================================
  // State register; only reset leaves the failed state
  // ==========================================================
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= TOP_RST;
    end else begin
      r <= next_r;
    end
  end

  assign o_cpu_clk        = r.cpu_clk;
  assign o_cpu_clk_src    = r.src;
  assign o_clock_fail_irq = r.fail_irq;
  assign o_pll_power_on   = r.pll_power;
  assign o_mode_ready     = r.ready;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_overflow;
    wd_if.overflow && wd_active;
  endsequence

  sequence s_failed_over;
    r.src == csow_pkg::CSOW_SRC_FREE_RUN && r.fail_irq && r.pll_power;
  endsequence

  property p_failover;
    s_overflow |=> s_failed_over;
  endproperty

  a_wd_mode_only: assert property (r.src == csow_pkg::CSOW_SRC_PLL |->
    !wd_if.enable && wd_if.count == 8'h00) else $error("watchdog active in PLL mode");
  a_wd_default_on: assert property ($rose(r.ready) && r.src != csow_pkg::CSOW_SRC_PLL
    |-> wd_if.enable) else $error("watchdog not enabled after reset");
  a_wd_disable_bit: assert property (
    i_system_config_reg[`CSOW_OSC_WATCH_DISABLE_BIT] && r.state == csow_pkg::CSOW_ST_RUN
    |=> !wd_if.enable) else $error("disable bit ignored");
  a_failover_src: assert property (p_failover)
    else $error("no failover after overflow");
  a_failover_irq: assert property (s_overflow ##1 !i_clock_fail_irq_clr [*2] |=> r.fail_irq)
    else $error("interrupt flag lost");
  a_failed_sticky: assert property (r.state == csow_pkg::CSOW_ST_FAILED
    |=> r.state == csow_pkg::CSOW_ST_FAILED && r.src == csow_pkg::CSOW_SRC_FREE_RUN)
    else $error("left failed state without reset");
  a_pll_off_idle: assert property (r.state == csow_pkg::CSOW_ST_RUN && !r.wd_enable &&
    r.src != csow_pkg::CSOW_SRC_PLL ##1 r.state == csow_pkg::CSOW_ST_RUN
    |-> !r.pll_power) else $error("PLL powered while watchdog off");
  a_pll_select: assert property ($rose(r.ready) && r.strap != `CSOW_STRAP_PRESCALE &&
    r.strap != `CSOW_STRAP_DIRECT |-> r.src == csow_pkg::CSOW_SRC_PLL)
    else $error("PLL not selected");
  a_div_two: assert property (r.src == csow_pkg::CSOW_SRC_PRESCALE && xtal_rise
    |=> r.cpu_clk != $past(r.cpu_clk)) else $error("prescaler missed edge");
  a_xtal_clears: assert property (xtal_edge && wd_active |=> wd_if.count == 8'h00)
    else $error("crystal edge did not clear counter");

  // Clock output per source
  a_direct_follow: assert property (r.src == csow_pkg::CSOW_SRC_DIRECT
    |=> r.cpu_clk == $past(xtal_level)) else $error("direct clock not following crystal");
  a_free_run_clk: assert property (r.src == csow_pkg::CSOW_SRC_FREE_RUN
    |=> r.cpu_clk == $past(r.fr_level)) else $error("CPU clock not on free-running clock");
  a_pll_steady: assert property (r.src == csow_pkg::CSOW_SRC_PLL && !xtal_rise
    |=> r.half_per == $past(r.half_per)) else $error("PLL period moved between resyncs");
endmodule

/* File: rtl/csow_defs.svh */
// Constants of the clock source with oscillator watchdog
`ifndef CSOW_DEFS_SVH
`define CSOW_DEFS_SVH

// ==========================================================
// Strap codes and configuration field
// ==========================================================
`define CSOW_STRAP_PRESCALE        3'h1
`define CSOW_STRAP_DIRECT          3'h3
`define CSOW_SYS_CFG_W             16
`define CSOW_OSC_WATCH_DISABLE_BIT 4
// Multiply factor per strap code, one nibble per code, code 0 lowest
`define CSOW_PLL_FACTOR_TABLE      32'h2345_0203

// ==========================================================
// Timing
// ==========================================================
`define CSOW_WD_OVF_TICKS          16
`define CSOW_REF_PERIOD_PS         5000
`define CSOW_FREE_RUN_PERIOD_NS    40
`define CSOW_FREE_RUN_HALF_CYC     ((`CSOW_FREE_RUN_PERIOD_NS * 1000) / (2 * `CSOW_REF_PERIOD_PS))
`define CSOW_STRAP_SETTLE_CYC      3

`endif

/* File: rtl/csow_pkg.sv */
// Types of the clock source with oscillator watchdog
package csow_pkg;

  // ==========================================================
  // Enumerations
  // ==========================================================
  typedef enum logic [1:0] {
    CSOW_SRC_DIRECT,
    CSOW_SRC_PRESCALE,
    CSOW_SRC_PLL,
    CSOW_SRC_FREE_RUN
  } csow_src_t;

  typedef enum logic [1:0] {
    CSOW_ST_STRAP,
    CSOW_ST_RUN,
    CSOW_ST_FAILED
  } csow_state_t;

  // ==========================================================
  // Module state records
  // ==========================================================
  typedef struct packed {
    csow_state_t state;
    csow_src_t   src;
    logic [1:0]  settle;
    logic [2:0]  strap;
    logic [3:0]  factor;
    logic        wd_enable;
    logic        fail_irq;
    logic        cpu_clk;
    logic        pll_power;
    logic        ready;
    logic [7:0]  fr_div;
    logic        fr_level;
    logic [15:0] per_cnt;
    logic [15:0] half_per;
    logic [15:0] ph_cnt;
    logic [3:0]  edge_cnt;
  } csow_top_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
  } csow_sync_t;

  typedef struct packed {
    logic [7:0] count;
    logic       overflow;
  } csow_cnt_t;

endpackage

/* File: rtl/csow_wd_if.sv */
// Link between the clock source control and the watchdog counter
interface csow_wd_if;
  logic       enable;
  logic       tick;
  logic       clear;
  logic       overflow;
  logic [7:0] count;

  modport ctrl (output enable, output tick, output clear, input overflow, input count);
  modport cnt  (input enable, input tick, input clear, output overflow, output count);
endinterface

/* File: rtl/csow_pin_sync.sv */
// Two-stage pin synchroniser with edge detection
module csow_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_edge
);
  csow_pkg::csow_sync_t r;
  csow_pkg::csow_sync_t next_r;

  if (WIDTH < 1 || WIDTH > 3) begin : g_bad_width
    $error("csow_pin_sync: WIDTH must be 1 to 3");
  end

  // ==========================================================
  // Shift chain; first stage feeds only the second
  // ==========================================================
  always_comb begin
    next_r    = r;
    next_r.s1 = 3'(i_pin);
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Edges seen between the settled stages
  assign o_level = r.s2[WIDTH-1:0];
  assign o_rise  = r.s2[WIDTH-1:0] & ~r.s3[WIDTH-1:0];
  assign o_edge  = r.s2[WIDTH-1:0] ^ r.s3[WIDTH-1:0];
endmodule

/* File: rtl/csow_wd_counter.sv */
// Oscillator watchdog counter on free-running ticks
`include "csow_defs.svh"

module csow_wd_counter #(
  parameter int unsigned OVF_TICKS = `CSOW_WD_OVF_TICKS
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  csow_wd_if.cnt    wd
);
  localparam logic [7:0] LAST = 8'(OVF_TICKS - 1);

  csow_pkg::csow_cnt_t r;
  csow_pkg::csow_cnt_t next_r;

  if (OVF_TICKS < 2 || OVF_TICKS > 255) begin : g_bad_ovf
    $error("csow_wd_counter: OVF_TICKS must be 2 to 255");
  end

  // ==========================================================
  // Count, clear and overflow
  // ==========================================================
  always_comb begin
    next_r          = r;
    next_r.overflow = 1'b0;
    if (!wd.enable || wd.clear) begin
      next_r.count = 8'h00;
    end else if (wd.tick) begin
      if (r.count == LAST) begin
        next_r.count    = 8'h00;
        next_r.overflow = 1'b1;
      end else begin
        next_r.count = r.count + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign wd.count    = r.count;
  assign wd.overflow = r.overflow;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  a_count_advances: assert property (wd.enable && wd.tick && !wd.clear && r.count != LAST
    |=> r.count == $past(r.count) + 8'h01) else $error("watchdog count missed a tick");
  a_count_clears: assert property (wd.enable && wd.clear
    |=> r.count == 8'h00 && !r.overflow) else $error("watchdog count not cleared");
  a_ovf_at_limit: assert property (r.overflow |-> $past(r.count) == LAST && $past(wd.tick))
    else $error("overflow at wrong count");
endmodule

/* File: verification/csow_testbench.sv */
// Self-checking testbench for the clock source with oscillator watchdog
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Signals and counters
  // ==========================================================
  logic                i_ref_clk;
  logic                i_reset_n;
  logic                i_crystal_input;
  logic [2:0]          i_clock_mode_straps;
  logic [15:0]         i_system_config_reg;
  logic                i_clock_fail_irq_clr;
  logic                o_cpu_clk;
  csow_pkg::csow_src_t o_cpu_clk_src;
  logic                o_clock_fail_irq;
  logic                o_pll_power_on;
  logic                o_mode_ready;
  int                  err_total;
  int                  n_compared;
  int                  cycles;
  int                  xcnt;
  int                  xtal_half;
  logic                xtal_run;

  csow_clock_source #(
    .WD_OVF_TICKS (16),
    .FR_HALF_CYC  (4),
    .STRAP_SETTLE (3)
  ) dut_u (
    .i_ref_clk            (i_ref_clk),
    .i_reset_n            (i_reset_n),
    .i_crystal_input      (i_crystal_input),
    .i_clock_mode_straps  (i_clock_mode_straps),
    .i_system_config_reg  (i_system_config_reg),
    .i_clock_fail_irq_clr (i_clock_fail_irq_clr),
    .o_cpu_clk            (o_cpu_clk),
    .o_cpu_clk_src        (o_cpu_clk_src),
    .o_clock_fail_irq     (o_clock_fail_irq),
    .o_pll_power_on       (o_pll_power_on),
    .o_mode_ready         (o_mode_ready)
  );

  // ==========================================================
  // Clock, crystal source and timeout
  // ==========================================================
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // Crystal toggles every xtal_half reference cycles while running
  initial begin
    cycles = 0;
    xcnt = 0;
    forever begin
      @(posedge i_ref_clk);
      #1;
      cycles++;
      if (cycles >= 40000) begin
        err_total++;
        $display("mismatch timeout expected 0 seen %0d", cycles);
        final_report();
      end
      if (xtal_run) begin
        xcnt++;
        if (xcnt >= xtal_half) begin
          i_crystal_input = ~i_crystal_input;
          xcnt = 0;
        end
      end
    end
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask

  // Reset with straps and config held, then wait for mode capture
  task automatic do_reset(input logic [2:0] s, input logic [15:0] c);
    @(posedge i_ref_clk);
    #1;
    i_reset_n = 1'b0;
    i_clock_mode_straps = s;
    i_system_config_reg = c;
    wait_cyc(1);
    check("src in reset", 16'(csow_pkg::CSOW_SRC_DIRECT), 16'(o_cpu_clk_src));
    check("irq in reset", 16'h0, 16'(o_clock_fail_irq));
    check("ready in reset", 16'h0, 16'(o_mode_ready));
    repeat (5) @(posedge i_ref_clk);
    #1;
    i_reset_n = 1'b1;
    wait_cyc(6);
    check("mode ready", 16'h1, 16'(o_mode_ready));
  endtask

  // Counts rises of the cpu clock and of the crystal over n cycles
  task automatic measure(input int n, output int cr, output int xr);
    logic pc;
    logic px;
    cr = 0;
    xr = 0;
    pc = o_cpu_clk;
    px = i_crystal_input;
    repeat (n) begin
      wait_cyc(1);
      if (o_cpu_clk && !pc) cr++;
      if (i_crystal_input && !px) xr++;
      pc = o_cpu_clk;
      px = i_crystal_input;
    end
  endtask

  task automatic wait_failover();
    for (int i = 0; i < 100 && o_cpu_clk_src !== csow_pkg::CSOW_SRC_FREE_RUN; i++) wait_cyc(1);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_direct();
    int cr;
    int xr;
    xtal_run = 1'b1;
    do_reset(3'h3, 16'h0000);
    wait_cyc(2);
    check("direct src", 16'(csow_pkg::CSOW_SRC_DIRECT), 16'(o_cpu_clk_src));
    check("direct pll power", 16'h1, 16'(o_pll_power_on));
    measure(240, cr, xr);
    check("direct follows", 16'h1, 16'((cr - xr) <= 1 && (xr - cr) <= 1));
    check("no failover running", 16'h0, 16'(o_clock_fail_irq));
    xtal_run = 1'b0;
    wait_cyc(110);
    check("early overflow", 16'(csow_pkg::CSOW_SRC_DIRECT), 16'(o_cpu_clk_src));
    wait_failover();
    check("failover src", 16'(csow_pkg::CSOW_SRC_FREE_RUN), 16'(o_cpu_clk_src));
    check("failover irq", 16'h1, 16'(o_clock_fail_irq));
    measure(80, cr, xr);
    check("free run rate", 16'h1, 16'(cr >= 9 && cr <= 11));
    xtal_run = 1'b1;
    wait_cyc(200);
    check("stays free run", 16'(csow_pkg::CSOW_SRC_FREE_RUN), 16'(o_cpu_clk_src));
    check("irq sticky", 16'h1, 16'(o_clock_fail_irq));
    @(posedge i_ref_clk);
    #1;
    i_clock_fail_irq_clr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_clock_fail_irq_clr = 1'b0;
    wait_cyc(2);
    check("irq cleared", 16'h0, 16'(o_clock_fail_irq));
    check("clear keeps src", 16'(csow_pkg::CSOW_SRC_FREE_RUN), 16'(o_cpu_clk_src));
    do_reset(3'h3, 16'h0000);
    check("reset restores", 16'(csow_pkg::CSOW_SRC_DIRECT), 16'(o_cpu_clk_src));
    $display("test direct done");
  endtask

  task automatic t_prescale();
    int cr;
    int xr;
    xtal_run = 1'b1;
    do_reset(3'h1, 16'h0010);
    wait_cyc(3);
    check("prescale src", 16'(csow_pkg::CSOW_SRC_PRESCALE), 16'(o_cpu_clk_src));
    check("pll off", 16'h0, 16'(o_pll_power_on));
    measure(240, cr, xr);
    check("half rate", 16'h1, 16'((2 * cr - xr) <= 2 && (xr - 2 * cr) <= 2));
    xtal_run = 1'b0;
    wait_cyc(300);
    check("disabled no failover", 16'(csow_pkg::CSOW_SRC_PRESCALE), 16'(o_cpu_clk_src));
    check("disabled no irq", 16'h0, 16'(o_clock_fail_irq));
    @(posedge i_ref_clk);
    #1;
    i_system_config_reg = 16'h0000;
    wait_cyc(3);
    check("enabled pll on", 16'h1, 16'(o_pll_power_on));
    wait_cyc(100);
    wait_failover();
    check("prescale failover", 16'(csow_pkg::CSOW_SRC_FREE_RUN), 16'(o_cpu_clk_src));
    check("prescale irq", 16'h1, 16'(o_clock_fail_irq));
    $display("test prescale done");
  endtask

  task automatic t_pll();
    logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    int         facts [6] = '{3, 2, 5, 4, 3, 2};
    // Slow crystal for factors 4 and 5 so the locked half period is whole
    int         halfs [6] = '{6, 6, 60, 60, 6, 6};
    int         cr;
    int         xr;
    for (int k = 0; k < 6; k++) begin
      xtal_run = 1'b1;
      xtal_half = halfs[k];
      do_reset(codes[k], 16'h0000);
      wait_cyc(2);
      check("pll src", 16'(csow_pkg::CSOW_SRC_PLL), 16'(o_cpu_clk_src));
      check("pll power", 16'h1, 16'(o_pll_power_on));
      wait_cyc(halfs[k] * 80);
      measure(halfs[k] * 20, cr, xr);
      check("pll rate", 16'h1, 16'((cr - xr * facts[k]) <= 3 && (xr * facts[k] - cr) <= 3));
      xtal_run = 1'b0;
      wait_cyc(300);
      check("pll no watchdog", 16'(csow_pkg::CSOW_SRC_PLL), 16'(o_cpu_clk_src));
      check("pll no irq", 16'h0, 16'(o_clock_fail_irq));
    end
    $display("test pll done");
  endtask

  // ==========================================================
  // Closing report and main sequence
  // ==========================================================
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    err_total = 0;
    n_compared = 0;
    xtal_run = 1'b0;
    xtal_half = 6;
    i_reset_n = 1'b0;
    i_crystal_input = 1'b0;
    i_clock_mode_straps = 3'h3;
    i_system_config_reg = 16'h0000;
    i_clock_fail_irq_clr = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    t_direct();
    t_prescale();
    t_pll();
    final_report();
  end
endmodule
